// *** rtl/wpf_framer.sv ***
// ppdu framer: apb registers, payload fifo, serial bit stream out
// assumes: downstream modulator on pclk paces bits with mod_ready
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "wpf_params.svh"

module wpf_framer
	import wpf_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int FIFO_AW = $clog2(FIFO_DEPTH)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mod_ready,
	output logic tx_bit,
	output logic tx_valid,
	output logic hdr_start,
	output logic psdu_start,
	output logic [1:0] tx_cnst,
	output logic [2:0] tx_sf,
	output logic [16:0] sym_rate,
	output logic busy
);
	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [14:0] bch_par(input logic [15:0] d);
		logic [14:0] r;
		logic fb;
		r = '0;
		for (int i = `WPF_BCH_K - 1; i >= 0; i--) begin
			fb = d[i] ^ r[14];
			r = {r[13:0], 1'b0} ^ (fb ? `WPF_BCH_G : 15'h0000);
		end
		return r;
	endfunction: bch_par

	function automatic logic [7:0] hcs8(input logic [15:0] d);
		logic [7:0] c;
		c = '0;
		for (int i = 0; i < `WPF_BCH_K; i++) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `WPF_HCS_POLY : 8'h00);
		end
		return c;
	endfunction: hcs8

	// returns {new state, scrambled data}; x^7 + x^4 + 1
	function automatic logic [22:0] scr16(input logic [6:0] s,
			input logic [15:0] d);
		logic [15:0] o;
		logic fb;
		o = '0;
		for (int i = 0; i < `WPF_BCH_K; i++) begin
			fb = s[6] ^ s[3];
			o[i] = d[i] ^ fb;
			s = {s[5:0], fb};
		end
		return {s, o};
	endfunction: scr16

	function automatic wpf_mod_t pay_mod(input logic [2:0] band,
			input logic [1:0] rate);
		wpf_mod_t m;
		m.sf = `WPF_SF1;
		m.cnst = (rate == 2'h0) ? `WPF_MOD_DBPSK :
			(rate == 2'h3) ? `WPF_MOD_D8PSK : `WPF_MOD_DQPSK;
		unique case (band)
			`WPF_BAND_402, `WPF_BAND_863: begin
			end
			`WPF_BAND_902: begin
				m.cnst = (rate[1] == 1'b0) ? `WPF_MOD_DBPSK : m.cnst;
				m.sf = (rate == 2'h0) ? `WPF_SF2 : `WPF_SF1;
			end
			`WPF_BAND_950: begin
				m.cnst = (rate[1] == 1'b0) ? `WPF_MOD_DBPSK : m.cnst;
			end
			// unknown band codes fall back to the 2.4 GHz table
			default: begin
				m.cnst = (rate == 2'h3) ? `WPF_MOD_DQPSK : `WPF_MOD_DBPSK;
				m.sf = (rate == 2'h0) ? `WPF_SF4 :
					(rate == 2'h1) ? `WPF_SF2 : `WPF_SF1;
			end
		endcase
		return m;
	endfunction: pay_mod

	function automatic logic [2:0] hdr_sf(input logic [2:0] band);
		return (band == `WPF_BAND_902) ? `WPF_SF2 :
			(band inside {`WPF_BAND_402, `WPF_BAND_950, `WPF_BAND_863}) ?
			`WPF_SF1 : `WPF_SF4;
	endfunction: hdr_sf

	function automatic logic [16:0] band_sr(input logic [2:0] band);
		logic [16:0] r;
		unique case (band)
			`WPF_BAND_402: r = `WPF_SR_402;
			`WPF_BAND_902: r = `WPF_SR_902;
			`WPF_BAND_950: r = `WPF_SR_950;
			`WPF_BAND_863: r = `WPF_SR_863;
			default: r = `WPF_SR_2G4;
		endcase
		return r;
	endfunction: band_sr

	// ****************************************************************
	// apb slave
	// ****************************************************************
	wpf_state_t state_ff;
	wpf_cfg_t cfg_ff;
	logic [7:0] len_ff;
	logic start_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [15:0] fifo_data;
	logic [FIFO_AW:0] fifo_count;
	logic acc;
	logic wr_done;
	logic data_hit;
	logic mapped;

	assign acc = psel && penable;
	assign wr_done = acc && pready_ff && pwrite;
	assign data_hit = paddr == `WPF_OFS_DATA;
	assign mapped = paddr == `WPF_OFS_CTRL || paddr == `WPF_OFS_LEN ||
		paddr == `WPF_OFS_STAT || data_hit;

	// a full fifo holds the data write in wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else if (pce) begin
			pready_ff <= acc && !pready_ff &&
				!(pwrite && data_hit && !fifo_in_ready);
			pslverr_ff <= acc && !pready_ff && !mapped;
			prdata_ff <= '0;
			if (acc && !pready_ff && !pwrite) begin
				unique case (paddr)
					`WPF_OFS_CTRL: prdata_ff <= {16'h0000, cfg_ff, 1'b0};
					`WPF_OFS_LEN: prdata_ff <= {24'h000000, len_ff};
					`WPF_OFS_STAT: prdata_ff <= {16'h0000,
						8'(fifo_count), 3'h0, state_ff, !fifo_in_ready,
						!fifo_out_valid, busy};
					default: prdata_ff <= '0;
				endcase
			end
		end
	end

	// start is kept until the idle sequencer takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= `WPF_CTRL_RESET;
			len_ff <= '0;
			start_ff <= 1'b0;
		end else if (pce) begin
			if (state_ff == ST_IDLE) begin
				start_ff <= 1'b0;
			end
			if (wr_done && paddr == `WPF_OFS_CTRL && !busy) begin
				cfg_ff <= pwdata[`WPF_CTRL_CHAN_HI:`WPF_CTRL_BAND_LO];
				start_ff <= pwdata[`WPF_CTRL_START];
			end
			if (wr_done && paddr == `WPF_OFS_LEN && !busy) begin
				len_ff <= pwdata[7:0];
			end
		end
	end

	// two payload bytes per word, low byte sent first
	wpf_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.ce(pce),
		.in_valid(wr_done && data_hit),
		.in_ready(fifo_in_ready),
		.in_data(pwdata[15:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data),
		.count(fifo_count)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	logic ld;
	logic pre_bit;
	logic pre_last;
	logic [61:0] hdr_sr_ff;
	logic [5:0] hdr_cnt_ff;
	logic [30:0] blk_sr_ff;
	logic [4:0] blk_left_ff;
	logic [7:0] bytes_left_ff;
	logic [6:0] scr_ff;
	logic [15:0] hinfo;
	logic [22:0] scr_res;
	logic [15:0] pay_word;
	logic [30:0] blk_new;
	logic [4:0] blk_len;
	logic odd_last;
	wpf_mod_t pmod;

	assign ld = !tx_valid || mod_ready;
	assign hinfo = {4'h0, cfg_ff.burst, len_ff, 1'b0, cfg_ff.rate};
	assign odd_last = bytes_left_ff == 8'h01;
	// the odd last byte is padded with zeros before scrambling
	assign pay_word = odd_last ? {8'h00, fifo_data[7:0]} : fifo_data;
	assign scr_res = scr16(scr_ff, pay_word);
	assign blk_new = {bch_par(scr_res[15:0]), scr_res[15:0]};
	assign blk_len = cfg_ff.bch ? 5'(`WPF_BCH_N) :
		(odd_last ? 5'h08 : 5'(`WPF_BCH_K));
	assign fifo_pop = pce && ld && state_ff == ST_PSDU && fifo_out_valid &&
		blk_left_ff == '0 && bytes_left_ff != '0;
	assign pmod = pay_mod(cfg_ff.band, cfg_ff.rate);

	wpf_preamble u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.ce(pce),
		.start(state_ff == ST_IDLE),
		.sel(cfg_ff.chan[0]),
		.adv(ld && state_ff == ST_PRE),
		.bit_o(pre_bit),
		.last_o(pre_last)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else if (pce && ld) begin
			unique case (state_ff)
				ST_IDLE: if (start_ff) state_ff <= ST_PRE;
				ST_PRE: if (pre_last) state_ff <= ST_HDR;
				ST_HDR: if (hdr_cnt_ff == 6'(`WPF_HDR_BITS - 1)) begin
					state_ff <= (len_ff == '0) ? ST_IDLE : ST_PSDU;
				end
				ST_PSDU: if (blk_left_ff <= 5'h01 && bytes_left_ff == '0 &&
						!(blk_left_ff == '0 && fifo_pop)) begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// header: two bch(31,16) words, fields then check sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_sr_ff <= '0;
			hdr_cnt_ff <= '0;
		end else if (pce && ld) begin
			if (state_ff == ST_IDLE) begin
				hdr_sr_ff <= {bch_par({8'h00, hcs8(hinfo)}), 8'h00,
					hcs8(hinfo), bch_par(hinfo), hinfo};
				hdr_cnt_ff <= '0;
			end else if (state_ff == ST_HDR) begin
				hdr_sr_ff <= hdr_sr_ff >> 1;
				hdr_cnt_ff <= hdr_cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_sr_ff <= '0;
			blk_left_ff <= '0;
			bytes_left_ff <= '0;
			scr_ff <= `WPF_SCR_SEED;
		end else if (pce && ld) begin
			if (state_ff == ST_IDLE) begin
				bytes_left_ff <= len_ff;
				blk_left_ff <= '0;
				scr_ff <= `WPF_SCR_SEED;
			end else if (fifo_pop) begin
				blk_sr_ff <= blk_new >> 1;
				blk_left_ff <= blk_len - 1'b1;
				bytes_left_ff <= odd_last ? 8'h00 : bytes_left_ff - 8'h02;
				scr_ff <= scr_res[22:16];
			end else if (state_ff == ST_PSDU && blk_left_ff != '0) begin
				blk_sr_ff <= blk_sr_ff >> 1;
				blk_left_ff <= blk_left_ff - 1'b1;
			end
		end
	end

	// ****************************************************************
	// output stage
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_bit <= 1'b0;
			tx_valid <= 1'b0;
			hdr_start <= 1'b0;
			psdu_start <= 1'b0;
		end else if (pce) begin
			if (mod_ready) begin
				hdr_start <= 1'b0;
				psdu_start <= 1'b0;
			end
			if (ld) begin
				tx_valid <= 1'b0;
				unique case (state_ff)
					ST_IDLE: tx_bit <= 1'b0;
					ST_PRE: begin
						tx_bit <= pre_bit;
						tx_valid <= 1'b1;
					end
					ST_HDR: begin
						tx_bit <= hdr_sr_ff[0];
						tx_valid <= 1'b1;
						hdr_start <= hdr_cnt_ff == '0;
					end
					ST_PSDU: begin
						if (blk_left_ff != '0) begin
							tx_bit <= blk_sr_ff[0];
							tx_valid <= 1'b1;
						end else if (fifo_pop) begin
							tx_bit <= blk_new[0];
							tx_valid <= 1'b1;
							psdu_start <= bytes_left_ff == len_ff;
						end
					end
				endcase
			end
		end
	end

	// modulation follows the bit that is presented
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnst <= `WPF_MOD_DBPSK;
			tx_sf <= `WPF_SF1;
			sym_rate <= `WPF_SR_2G4;
			busy <= 1'b0;
		end else if (pce && ld) begin
			busy <= state_ff != ST_IDLE || start_ff;
			unique case (state_ff)
				ST_IDLE: begin
					sym_rate <= band_sr(cfg_ff.band);
					tx_cnst <= `WPF_MOD_DBPSK;
					tx_sf <= `WPF_SF1;
				end
				ST_PRE: begin
				end
				ST_HDR: begin
					tx_cnst <= `WPF_MOD_DBPSK;
					tx_sf <= hdr_sf(cfg_ff.band);
				end
				ST_PSDU: if (fifo_pop && bytes_left_ff == len_ff) begin
					tx_cnst <= pmod.cnst;
					tx_sf <= pmod.sf;
				end
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

endmodule: wpf_framer

// *** inc/wpf_params.svh ***
// constants of the ppdu framer: register map, fields, codes, tables
// assumes: included by bare name from the package and the framer and preamble rtl files
`ifndef WPF_PARAMS_SVH
`define WPF_PARAMS_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define WPF_OFS_CTRL 8'h00
`define WPF_OFS_LEN 8'h04
`define WPF_OFS_STAT 8'h08
`define WPF_OFS_DATA 8'h0C

// ****************************************************************
// control field positions
// ****************************************************************
`define WPF_CTRL_START 0
`define WPF_CTRL_BAND_LO 1
`define WPF_CTRL_BAND_HI 3
`define WPF_CTRL_RATE_LO 4
`define WPF_CTRL_RATE_HI 5
`define WPF_CTRL_BCH 6
`define WPF_CTRL_BURST 7
`define WPF_CTRL_CHAN_LO 8
`define WPF_CTRL_CHAN_HI 15
`define WPF_CTRL_RESET 15'h0000

// ****************************************************************
// band codes and header symbol rates (ksps x 100)
// ****************************************************************
`define WPF_BAND_2G4 3'h0
`define WPF_BAND_402 3'h1
`define WPF_BAND_902 3'h2
`define WPF_BAND_950 3'h3
`define WPF_BAND_863 3'h4
`define WPF_SR_2G4 17'h0F6B6
`define WPF_SR_402 17'h044ED
`define WPF_SR_902 17'h07B5B
`define WPF_SR_950 17'h061A8
`define WPF_SR_863 17'h030D4

// ****************************************************************
// constellations, spreading factors
// ****************************************************************
`define WPF_MOD_DBPSK 2'h0
`define WPF_MOD_DQPSK 2'h1
`define WPF_MOD_D8PSK 2'h2
`define WPF_SF1 3'h1
`define WPF_SF2 3'h2
`define WPF_SF4 3'h4

// ****************************************************************
// coding: bch(31,16) generator low bits, hcs crc8, scrambler
// ****************************************************************
`define WPF_BCH_K 16
`define WPF_BCH_N 31
`define WPF_BCH_G 15'h0FAF
`define WPF_HCS_POLY 8'h07
`define WPF_SCR_SEED 7'h7F
`define WPF_HDR_BITS 7'h3E
`define WPF_PRE_MSEQ 7'h3F
`define WPF_PRE_LAST 7'h47
`define WPF_PRE_SEED_A 6'h3F
`define WPF_PRE_SEED_B 6'h15

`endif

// *** inc/wpf_pkg.sv ***
// types of the ppdu framer
// assumes: wpf_params.svh on the include path
`include "wpf_params.svh"
package wpf_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE,
		ST_HDR,
		ST_PSDU
	} wpf_state_t;

	typedef struct packed {
		logic [7:0] chan;
		logic burst;
		logic bch;
		logic [1:0] rate;
		logic [2:0] band;
	} wpf_cfg_t;

	typedef struct packed {
		logic [1:0] cnst;
		logic [2:0] sf;
	} wpf_mod_t;

endpackage: wpf_pkg

// *** rtl/wpf_fifo.sv ***
// synchronous fifo for payload words
// assumes: single clock, both sides on that clock
`timescale 1ns/100ps
module wpf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic push;
	logic pop;

	assign count = wr_ff - rd_ff;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = wr_ff != rd_ff;
	assign out_data = mem[rd_ff[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ff <= '0;
		end else if (ce && push) begin
			wr_ff <= wr_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (ce && push) begin
			mem[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ff <= '0;
		end else if (ce && pop) begin
			rd_ff <= rd_ff + 1'b1;
		end
	end

endmodule: wpf_fifo

// *** rtl/wpf_preamble.sv ***
// preamble source: m-sequence of 63 chips then 010101010
// assumes: adv only while running; sel fixed during a preamble
`timescale 1ns/100ps
`include "wpf_params.svh"
module wpf_preamble #(
	parameter logic [5:0] SEED_A = `WPF_PRE_SEED_A,
	parameter logic [5:0] SEED_B = `WPF_PRE_SEED_B
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire logic sel,
	input wire logic adv,
	output logic bit_o,
	output logic last_o
);
	logic [5:0] lfsr_ff;
	logic [6:0] cnt_ff;

	// x^6 + x + 1, maximal length 63; two seeds give two sequences
	assign bit_o = (cnt_ff < `WPF_PRE_MSEQ) ? lfsr_ff[0] : ~cnt_ff[0];
	assign last_o = cnt_ff == `WPF_PRE_LAST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_ff <= `WPF_PRE_SEED_A;
			cnt_ff <= '0;
		end else if (ce) begin
			if (start) begin
				lfsr_ff <= sel ? SEED_B : SEED_A;
				cnt_ff <= '0;
			end else if (adv) begin
				lfsr_ff <= {lfsr_ff[0] ^ lfsr_ff[1], lfsr_ff[5:1]};
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

endmodule: wpf_preamble

// *** sim/wpf_mod_model.sv ***
// downstream modulator stand-in: takes one bit per ready cycle
// assumes: same pclk as the framer, slow set by the bench
`timescale 1ns/100ps
module wpf_mod_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	output logic mod_ready
);
	logic [2:0] tick_ff;
	// stalls three cycles in four so held bits get exercised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_ff <= 3'h0;
			mod_ready <= 1'b0;
		end else begin
			tick_ff <= tick_ff + 3'h1;
			mod_ready <= !slow || tick_ff[1:0] == 2'h3;
		end
	end
endmodule: wpf_mod_model

// *** sim/wpf_framer_assertions.sv ***
// checker of the ppdu framer top ports
// assumes: bound into wpf_framer, one pclk domain
`timescale 1ns/100ps
`include "wpf_params.svh"
module wpf_framer_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mod_ready,
	input wire logic tx_bit,
	input wire logic tx_valid,
	input wire logic hdr_start,
	input wire logic psdu_start,
	input wire logic [1:0] tx_cnst,
	input wire logic [2:0] tx_sf,
	input wire logic [16:0] sym_rate,
	input wire logic busy
);
	logic [7:0] pos_ff;
	logic [2:0] hsf;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// bits taken since the packet began, saturating
	// ****
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pos_ff <= 8'h00;
		else if (pce && !busy)
			pos_ff <= 8'h00;
		else if (pce && tx_valid && mod_ready && pos_ff != 8'hFF)
			pos_ff <= pos_ff + 8'h01;
	end
	assign hsf = (sym_rate == `WPF_SR_2G4) ? `WPF_SF4 :
		(sym_rate == `WPF_SR_902) ? `WPF_SF2 : `WPF_SF1;
	sequence s_stall;
		pce && tx_valid && !mod_ready;
	endsequence
	sequence s_hdr_taken;
		pce && tx_valid && mod_ready && hdr_start;
	endsequence
	property p_pready_pulse;
		pce && pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("pready held past one cycle");
	property p_slverr;
		pready |-> pslverr == !(paddr inside {`WPF_OFS_CTRL,
			`WPF_OFS_LEN, `WPF_OFS_STAT, `WPF_OFS_DATA});
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("pslverr does not match address");
	property p_hold;
		s_stall |=> tx_valid && $stable(tx_bit) && $stable(hdr_start)
			&& $stable(psdu_start);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stalled bit changed");
	property p_hdr_once;
		s_hdr_taken |=> !hdr_start;
	endproperty
	a_hdr_once: assert property (p_hdr_once)
		else $error("header strobe repeated");
	property p_hdr_pos;
		hdr_start && tx_valid |-> pos_ff == 8'h48;
	endproperty
	a_hdr_pos: assert property (p_hdr_pos)
		else $error("header not after 72 preamble bits");
	property p_psdu_pos;
		psdu_start && tx_valid |-> pos_ff == 8'h86;
	endproperty
	a_psdu_pos: assert property (p_psdu_pos)
		else $error("payload not after 62 header bits");
	property p_hdr_mod;
		hdr_start && tx_valid |-> tx_cnst == `WPF_MOD_DBPSK && tx_sf == hsf;
	endproperty
	a_hdr_mod: assert property (p_hdr_mod)
		else $error("header modulation or spreading wrong");
	property p_rate_fixed;
		busy && tx_valid ##1 busy |-> $stable(sym_rate);
	endproperty
	a_rate_fixed: assert property (p_rate_fixed)
		else $error("symbol rate changed within packet");
	property p_band_rate;
		sym_rate inside {`WPF_SR_2G4, `WPF_SR_402, `WPF_SR_902,
			`WPF_SR_950, `WPF_SR_863};
	endproperty
	a_band_rate: assert property (p_band_rate)
		else $error("symbol rate not a band value");
	property p_pre_tail;
		tx_valid && pos_ff >= 8'h3F && pos_ff <= 8'h47 |-> tx_bit == !pos_ff[0];
	endproperty
	a_pre_tail: assert property (p_pre_tail)
		else $error("preamble tail not alternating");
	property p_hdr_resv;
		tx_valid && (pos_ff == 8'h4A || (pos_ff >= 8'h54 && pos_ff <= 8'h57))
			|-> !tx_bit;
	endproperty
	a_hdr_resv: assert property (p_hdr_resv)
		else $error("reserved header bit set");
endmodule: wpf_framer_chk

bind wpf_framer wpf_framer_chk i_wpf_framer_chk (.pclk, .presetn, .pce,
	.paddr, .pready, .pslverr, .mod_ready, .tx_bit, .tx_valid, .hdr_start,
	.psdu_start, .tx_cnst, .tx_sf, .sym_rate, .busy);

// *** sim/wpf_framer_test.sv ***
// self-checking bench of the ppdu framer
// assumes: rtl, inc, modulator model and checker compiled before it
`timescale 1ns/100ps
`include "wpf_params.svh"
module wpf_framer_test;
	logic pclk, presetn, pce, psel, penable, pwrite, slow, er;
	logic pready, pslverr, mod_ready, tx_bit, tx_valid, hdr_start;
	logic psdu_start, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] tx_cnst, exp_pc;
	logic [2:0] tx_sf, exp_sf, exp_ps;
	logic [16:0] sym_rate, exp_sr;
	logic [1:0] exp_q[$];
	logic [62:0] pre_v, pre_a;
	int n_mismatch, compares, idx, seed, b;
	wpf_framer #(.FIFO_DEPTH(32)) i_wpf_framer (.pclk, .presetn, .pce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mod_ready, .tx_bit, .tx_valid, .hdr_start, .psdu_start, .tx_cnst,
		.tx_sf, .sym_rate, .busy);
	wpf_mod_model i_wpf_mod_model (.pclk, .presetn, .slow, .mod_ready);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask: chk
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask: final_report
	// ****
	// apb master: hold request until pready, sampled at the rising edge
	// ****
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 4000; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 4000) begin
			n_mismatch++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask: apb
	task automatic put(input int n, input logic c, input logic [31:0] v);
		for (int i = 0; i < n; i++)
			exp_q.push_back({c, v[i]});
	endtask: put
	// ****
	// one packet: fill fifo, start, wait for the stream to finish
	// ****
	task automatic pkt(input logic [2:0] band, input logic [1:0] rate,
		input logic bch, input logic burst, input logic [7:0] chan,
		input logic [7:0] len);
		int i, nw;
		nw = (len + 1) / 2;
		for (i = 0; i < nw; i++)
			apb(1'b1, `WPF_OFS_DATA, $random(seed), rd, er);
		apb(1'b0, `WPF_OFS_STAT, 32'h0, rd, er);
		chk("fifo_cnt", rd[15:8], nw);
		chk("fifo_full", rd[2], nw == 32);
		apb(1'b1, `WPF_OFS_LEN, {24'h0, len}, rd, er);
		case (band)
			`WPF_BAND_402: {exp_sf, exp_sr} = {`WPF_SF1, `WPF_SR_402};
			`WPF_BAND_902: {exp_sf, exp_sr} = {`WPF_SF2, `WPF_SR_902};
			`WPF_BAND_950: {exp_sf, exp_sr} = {`WPF_SF1, `WPF_SR_950};
			`WPF_BAND_863: {exp_sf, exp_sr} = {`WPF_SF1, `WPF_SR_863};
			default: {exp_sf, exp_sr} = {`WPF_SF4, `WPF_SR_2G4};
		endcase
		exp_ps = `WPF_SF1;
		exp_pc = (rate == 2'h0) ? `WPF_MOD_DBPSK : (rate == 2'h3) ?
			`WPF_MOD_D8PSK : `WPF_MOD_DQPSK;
		if (band == `WPF_BAND_902 || band == `WPF_BAND_950)
			exp_pc = rate[1] ? exp_pc : `WPF_MOD_DBPSK;
		if (band == `WPF_BAND_902 && rate == 2'h0)
			exp_ps = `WPF_SF2;
		if (exp_sf == `WPF_SF4) begin
			exp_pc = (rate == 2'h3) ? `WPF_MOD_DQPSK : `WPF_MOD_DBPSK;
			exp_ps = (rate == 2'h0) ? `WPF_SF4 :
				(rate == 2'h1) ? `WPF_SF2 : `WPF_SF1;
		end
		idx = 0;
		put(63, 1'b0, 32'h0);
		put(9, 1'b1, 32'h0AA);
		put(16, 1'b1, {20'h0, burst, len, 1'b0, rate});
		put(15, 1'b0, 32'h0);
		put(8, 1'b0, 32'h0);
		put(8, 1'b1, 32'h0);
		put(15, 1'b0, 32'h0);
		for (i = 0; i < nw; i++)
			put(bch ? 31 : (len[0] && i == nw - 1) ? 8 : 16, 1'b0, 32'h0);
		apb(1'b1, `WPF_OFS_CTRL, {16'h0, chan, burst, bch, rate, band, 1'b1},
			rd, er);
		apb(1'b0, `WPF_OFS_CTRL, 32'h0, rd, er);
		chk("ctrl_rd", rd, {16'h0, chan, burst, bch, rate, band, 1'b0});
		// start while busy must be ignored, else extra bits appear
		apb(1'b1, `WPF_OFS_CTRL, 32'h00000009, rd, er);
		for (i = 0; i < 20000 && (busy !== 1'b0 || exp_q.size() > 0); i++)
			@(negedge pclk);
		if (i == 20000) begin
			n_mismatch++;
			final_report();
		end
		repeat (8) @(negedge pclk);
		chk("idle_after", busy, 1'b0);
		chk("mseq_ones", $countones(pre_v), 32'h20);
	endtask: pkt
	always @(negedge pclk) begin
		if (presetn === 1'b1 && tx_valid === 1'b1 && mod_ready === 1'b1) begin
			if (hdr_start === 1'b1) begin
				chk("hdr_pos", idx, 32'h48);
				chk("hdr_sf", tx_sf, exp_sf);
				chk("hdr_cnst", tx_cnst, `WPF_MOD_DBPSK);
				chk("hdr_rate", sym_rate, exp_sr);
			end
			if (psdu_start === 1'b1) begin
				chk("psdu_pos", idx, 32'h86);
				chk("psdu_rate", sym_rate, exp_sr);
				chk("psdu_sf", tx_sf, exp_ps);
				chk("psdu_cnst", tx_cnst, exp_pc);
			end
			if (idx < 63)
				pre_v[idx] = tx_bit;
			if (exp_q.size() == 0)
				chk("extra_bit", 1'b1, 1'b0);
			else if (exp_q[0][1])
				chk("tx_bit", tx_bit, exp_q[0][0]);
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
			idx++;
		end
	end
	initial begin
		seed = 23053;
		n_mismatch = 0;
		compares = 0;
		idx = 0;
		{pce, presetn, psel, penable, pwrite, slow} = 6'h20;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("rst_sf", tx_sf, `WPF_SF1);
		chk("rst_sr", sym_rate, `WPF_SR_2G4);
		chk("rst_valid", tx_valid, 1'b0);
		apb(1'b0, `WPF_OFS_STAT, 32'h0, rd, er);
		chk("rst_stat", rd, 32'h00000002);
		apb(1'b0, `WPF_OFS_CTRL, 32'h0, rd, er);
		chk("rst_ctrl", rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0, rd, er);
		chk("unmap_err", er, 1'b1);
		chk("unmap_rd", rd, 32'h0);
		$display("test reset_regs done");
		for (b = 0; b < 6; b++) begin
			slow <= b[0];
			pkt(b[2:0], b[1:0], b[0], b[1], 8'(b * 37), 8'(b * 7 + 1));
			if (b > 0)
				chk("pre_sel", pre_v == pre_a, 1'b0);
			pre_a = pre_v;
		end
		$display("test band_loop done");
		slow <= 1'b1;
		pkt(3'h0, 2'h3, 1'b0, 1'b1, 8'h02, 8'h40);
		$display("test fifo_full done");
		final_report();
	end
endmodule: wpf_framer_test
